// ==== qhs_pkg.sv ====
// Shared constants and types for the quad UART host select, interrupt and ready logic
package qhs_pkg;
    localparam int NUM_CHAN = 4;
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic STYLE_RWLINE = 1'b0;
    localparam int CLK_MHZ = 100;
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYC - 1);
    // Host register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ACCESS = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h5;
    // Field positions
    localparam int CTRL_STYLE_BIT = 0;
    localparam int CTRL_FORCE_BIT = 1;
    localparam int ACC_ADDR_LSB = 0;
    localparam int ACC_CHAN_LSB = 3;
    localparam int ACC_READ_BIT = 5;
    localparam int ACC_DATA_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DATA_LSB = 8;
    localparam int NUM_EV = 4;
    localparam int EV_DONE = 0;
    localparam int EV_IRQ = 1;
    localparam int EV_ALL_TX_READY_N = 2;
    localparam int EV_ALL_RX_READY_N = 3;
    // Reset values
    localparam logic CTRL_STYLE_RST = STYLE_STROBE;
    localparam logic CTRL_FORCE_RST = 1'b0;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_SETUP = 4'h2,
        H_STROBE = 4'h4,
        H_HOLD = 4'h8
    } qhs_hstate_type;
endpackage

// ==== qhs_if.sv ====
// Pin-level carrier between the host controller and the quad UART select logic
interface qhs_if;
    logic busStyle;
    logic irqForceEnable;
    logic chanASelectN;
    logic chanBSelectN;
    logic chanCSelectN;
    logic chanDSelectN;
    logic [2:0] addr;
    logic rdStrobeN;
    logic wrStrobeN;
    logic [7:0] hostData;
    logic hostDataOeN;
    logic [7:0] devData;
    logic devDataOeN;
    logic [3:0] chanIrqOut;
    logic [3:0] chanIrqOeN;
    logic [3:0] chanTxReadyN;
    logic [3:0] chanRxReadyN;
    logic allTxReadyN;
    logic allRxReadyN;
    logic [7:0] busData;
    logic [3:0] chanIrqLevel;
    // Undriven data bus floats high
    assign busData = !devDataOeN ? devData : (!hostDataOeN ? hostData : 8'hff);
    // Undriven interrupt lines: pulled up in read/write-line mode, low otherwise
    assign chanIrqLevel = (chanIrqOut & ~chanIrqOeN) | (chanIrqOeN & {4{~busStyle}});
    modport device (
        input busStyle, irqForceEnable, chanASelectN, chanBSelectN, chanCSelectN, chanDSelectN,
        input addr, rdStrobeN, wrStrobeN, busData,
        output devData, devDataOeN, chanIrqOut, chanIrqOeN,
        output chanTxReadyN, chanRxReadyN, allTxReadyN, allRxReadyN
    );
    modport host (
        output busStyle, irqForceEnable, chanASelectN, chanBSelectN, chanCSelectN, chanDSelectN,
        output addr, rdStrobeN, wrStrobeN, hostData, hostDataOeN,
        input busData, chanIrqLevel, chanTxReadyN, chanRxReadyN, allTxReadyN, allRxReadyN
    );
endinterface

// ==== qhs_device_end.sv ====
// Device end: bus-style select decode, interrupt pin control and ready pins
// Function
// - Style pin high strobe bus, low read/write-line
// - Strobe mode: third select enables channel C
// - Line mode: third select is upper channel bit
// - Line mode: second select is lower channel bit
// - Fourth select picks D; ignored in line mode
// - Strobe mode: A interrupt driven when enabled
// - Line mode: A becomes shared open-drain interrupt
// - Strobe mode: B-D interrupts driven when enabled
// - Line mode: B-D interrupt pins held low
// - Force input overrides enable bit in strobe
// - Force input held low in line mode
// - Per-channel active-low transmit ready pin
// - DMA enabled: transmit ready becomes request
// - Per-channel active-low receive ready pin
// - DMA enabled: receive ready becomes request
// - Receive request only with extended bit set
// - Combined transmit ready is wired-OR of four
// - Combined receive ready is wired-OR of four
module qhs_device_end
    import qhs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    qhs_if.device bus,
    // Channel interrupt state
    input wire logic [3:0] chanIrq,
    input wire logic [3:0] modemIrqEnable,
    // Channel FIFO state and DMA
    input wire logic [3:0] txReady,
    input wire logic [3:0] rxReady,
    input wire logic [3:0] txDmaRequest,
    input wire logic [3:0] rxDmaRequest,
    input wire logic [3:0] extModeTxDma,
    input wire logic [3:0] extModeRxDma,
    // Channel register access
    input wire logic [7:0] coreRdata,
    output logic [3:0] coreSel,
    output logic [2:0] coreAddr,
    output logic [7:0] coreWdata,
    output logic coreWr,
    output logic coreRd
);
    typedef struct packed {
        // Pin registers
        logic [3:0] irqOut;
        logic [3:0] irqOeN;
        logic [3:0] txRdyN;
        logic [3:0] rxRdyN;
        logic allTxN;
        logic allRxN;
        logic [7:0] dOut;
        logic dOeN;
        // Channel side registers
        logic [3:0] sel;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        // Access tracking
        logic act;
        logic isWr;
    } qhs_dev_type;

    qhs_dev_type cur_ff;
    qhs_dev_type nxt_dev;

    always_comb begin
        logic [3:0] pick;
        logic [3:0] newSel;
        logic [1:0] lineChan;
        logic rdReq;
        logic wrReq;
        logic reqAct;
        logic en;
        pick = 4'h0;
        newSel = 4'h0;
        lineChan = 2'h0;
        rdReq = 1'b0;
        wrReq = 1'b0;
        reqAct = 1'b0;
        en = 1'b0;
        nxt_dev = cur_ff;
        nxt_dev.wr = 1'b0;
        nxt_dev.rd = 1'b0;

        // Access decode
        if (bus.busStyle == STYLE_STROBE) begin
            // One select per channel, each active low
            pick[0] = ~bus.chanASelectN;
            pick[1] = ~bus.chanBSelectN;
            pick[2] = ~bus.chanCSelectN;
            pick[3] = ~bus.chanDSelectN;
            // Overlapping chip selects are not an access
            if ($onehot(pick)) begin
                newSel = pick;
            end
            rdReq = ~bus.rdStrobeN;
            wrReq = ~bus.wrStrobeN;
            // Both strobes low at once is refused as well
            reqAct = (|newSel) & (rdReq ^ wrReq);
        end else begin
            // Channel number from the upper and lower address selects; fourth select unused
            lineChan = {bus.chanCSelectN, bus.chanBSelectN};
            if (lineChan == 2'h0) begin
                newSel = 4'h1;
            end else if (lineChan == 2'h1) begin
                newSel = 4'h2;
            end else if (lineChan == 2'h2) begin
                newSel = 4'h4;
            end else begin
                newSel = 4'h8;
            end
            // No separate read strobe here: the write line gives the direction
            wrReq = ~bus.wrStrobeN;
            rdReq = bus.wrStrobeN;
            // The single chip select starts and ends the access
            reqAct = ~bus.chanASelectN;
        end

        // Channel access launched at start, write committed at end
        // A read reaches the core at once so its data settles while the strobe is held;
        // a write waits for the strobe to end, since the host may still change the data
        if (reqAct && !cur_ff.act) begin
            nxt_dev.sel = newSel;
            nxt_dev.addr = bus.addr;
            nxt_dev.isWr = wrReq;
            nxt_dev.rd = rdReq;
        end
        if (reqAct && wrReq) begin
            nxt_dev.wdata = bus.busData;
        end
        if (cur_ff.act && !reqAct && cur_ff.isWr) begin
            nxt_dev.wr = 1'b1;
        end
        if (!reqAct && !(cur_ff.act && cur_ff.isWr)) begin
            nxt_dev.sel = 4'h0;
        end
        nxt_dev.act = reqAct;
        // Data pins driven only while a read is seen, so the host never meets a driven bus
        // Read data is registered: the pins change on clock edges only
        nxt_dev.dOeN = ~(reqAct & rdReq);
        nxt_dev.dOut = coreRdata;

        // Interrupt and ready pins per channel
        // Strobe style: each pin driven only while enabled, else left to float
        // Line style: channel A pin pulls low for any pending channel, B-D driven low
        // Ready pins follow the status, or carry the request high when DMA is enabled
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (bus.busStyle == STYLE_STROBE) begin
                en = modemIrqEnable[i] | bus.irqForceEnable;
                nxt_dev.irqOut[i] = chanIrq[i];
                nxt_dev.irqOeN[i] = ~en;
            end else if (i == 0) begin
                nxt_dev.irqOut[i] = 1'b0;
                nxt_dev.irqOeN[i] = ~(|chanIrq);
            end else begin
                nxt_dev.irqOut[i] = 1'b0;
                nxt_dev.irqOeN[i] = 1'b0;
            end
            if (extModeTxDma[i]) begin
                nxt_dev.txRdyN[i] = txDmaRequest[i];
            end else begin
                nxt_dev.txRdyN[i] = ~txReady[i];
            end
            if (extModeRxDma[i]) begin
                nxt_dev.rxRdyN[i] = rxDmaRequest[i];
            end else begin
                nxt_dev.rxRdyN[i] = ~rxReady[i];
            end
        end
        // Combined ready pins follow the ready status only, not the DMA requests
        nxt_dev.allTxN = ~(|txReady);
        nxt_dev.allRxN = ~(|rxReady);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Every pin idles inactive: no drive, ready pins high
            cur_ff <= '0;
            cur_ff.irqOeN <= 4'hf;
            cur_ff.txRdyN <= 4'hf;
            cur_ff.rxRdyN <= 4'hf;
            cur_ff.allTxN <= 1'b1;
            cur_ff.allRxN <= 1'b1;
            cur_ff.dOeN <= 1'b1;
        end else begin
            cur_ff <= nxt_dev;
        end
    end

    // Pin drive
    // Every pin comes straight from a register, so no pin follows an input glitch
    assign bus.devData = cur_ff.dOut;
    assign bus.devDataOeN = cur_ff.dOeN;
    assign bus.chanIrqOut = cur_ff.irqOut;
    assign bus.chanIrqOeN = cur_ff.irqOeN;
    assign bus.chanTxReadyN = cur_ff.txRdyN;
    assign bus.chanRxReadyN = cur_ff.rxRdyN;
    assign bus.allTxReadyN = cur_ff.allTxN;
    assign bus.allRxReadyN = cur_ff.allRxN;

    // Channel side
    assign coreSel = cur_ff.sel;
    assign coreAddr = cur_ff.addr;
    assign coreWdata = cur_ff.wdata;
    assign coreWr = cur_ff.wr;
    assign coreRd = cur_ff.rd;
endmodule

// ==== qhs_host_end.sv ====
// Host end: register-driven bus master and event interrupt for the quad UART pins
//
// Implementation choices: the address map and strobed register access.
module qhs_host_end
    import qhs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Interrupt
    output logic irq,
    // Pins
    qhs_if.host bus
);
    typedef struct packed {
        qhs_hstate_type st;
        logic [2:0] cnt;
        logic style;
        logic frcEn;
        logic rd;
        logic [7:0] rdData;
        logic [NUM_EV-1:0] evSt;
        logic [NUM_EV-1:0] evEn;
        logic irq;
        logic [31:0] rdata;
        logic [3:0] csN;
        logic [2:0] a;
        logic rdN;
        logic wrN;
        logic [7:0] dOut;
        logic dOeN;
        logic prevIrq;
        logic prevTx;
        logic prevRx;
    } qhs_host_type;

    qhs_host_type cur_ff;
    qhs_host_type nxt_host;

    always_comb begin
        logic [1:0] chan;
        logic [NUM_EV-1:0] set;
        logic [NUM_EV-1:0] clr;
        logic devIrq;
        logic busy;
        chan = 2'h0;
        set = '0;
        clr = '0;
        nxt_host = cur_ff;
        busy = (cur_ff.st != H_IDLE);
        // Device interrupt seen per bus style
        devIrq = cur_ff.style ? (|bus.chanIrqLevel) : ~bus.chanIrqLevel[0];

        if (regWr) begin
            if (regAddr == OFS_CTRL) begin
                if (!busy) begin
                    nxt_host.style = regWdata[CTRL_STYLE_BIT];
                    nxt_host.frcEn = regWdata[CTRL_FORCE_BIT] & regWdata[CTRL_STYLE_BIT];
                end
            end else if (regAddr == OFS_ACCESS) begin
                if (!busy) begin
                    chan = regWdata[ACC_CHAN_LSB +: 2];
                    nxt_host.st = H_SETUP;
                    nxt_host.rd = regWdata[ACC_READ_BIT];
                    nxt_host.a = regWdata[ACC_ADDR_LSB +: 3];
                    nxt_host.dOut = regWdata[ACC_DATA_LSB +: 8];
                    nxt_host.dOeN = regWdata[ACC_READ_BIT];
                    if (cur_ff.style == STYLE_STROBE) begin
                        nxt_host.csN = ~(4'h1 << chan);
                    end else begin
                        nxt_host.csN = {1'b1, chan, 1'b1};
                        nxt_host.wrN = regWdata[ACC_READ_BIT];
                    end
                end
            end else if (regAddr == OFS_IRQ_ENABLE) begin
                nxt_host.evEn = regWdata[NUM_EV-1:0];
            end else if (regAddr == OFS_IRQ_CLEAR) begin
                clr = regWdata[NUM_EV-1:0];
            end
        end

        nxt_host.rdata = 32'h0;
        if (regRd) begin
            if (regAddr == OFS_CTRL) begin
                nxt_host.rdata[CTRL_STYLE_BIT] = cur_ff.style;
                nxt_host.rdata[CTRL_FORCE_BIT] = cur_ff.frcEn;
            end else if (regAddr == OFS_STATUS) begin
                nxt_host.rdata[STAT_BUSY_BIT] = busy;
                nxt_host.rdata[STAT_DATA_LSB +: 8] = cur_ff.rdData;
            end else if (regAddr == OFS_IRQ_STATUS) begin
                nxt_host.rdata[NUM_EV-1:0] = cur_ff.evSt;
            end else if (regAddr == OFS_IRQ_ENABLE) begin
                nxt_host.rdata[NUM_EV-1:0] = cur_ff.evEn;
            end
        end

        case (cur_ff.st)
            H_SETUP: begin
                nxt_host.st = H_STROBE;
                nxt_host.cnt = 3'h0;
                if (cur_ff.style == STYLE_STROBE) begin
                    nxt_host.rdN = ~cur_ff.rd;
                    nxt_host.wrN = cur_ff.rd;
                end else begin
                    nxt_host.csN[0] = 1'b0;
                end
            end
            H_STROBE: begin
                nxt_host.cnt = cur_ff.cnt + 3'h1;
                if (cur_ff.cnt == STROBE_LAST) begin
                    nxt_host.st = H_HOLD;
                    if (cur_ff.rd) begin
                        nxt_host.rdData = bus.busData;
                    end
                    nxt_host.rdN = 1'b1;
                    if (cur_ff.style == STYLE_STROBE) begin
                        nxt_host.wrN = 1'b1;
                    end else begin
                        nxt_host.csN[0] = 1'b1;
                    end
                end
            end
            H_HOLD: begin
                nxt_host.st = H_IDLE;
                nxt_host.csN = 4'hf;
                nxt_host.wrN = 1'b1;
                nxt_host.dOeN = 1'b1;
                set[EV_DONE] = 1'b1;
            end
            default: begin
            end
        endcase

        // Rising-edge events; a set beats a clear in the same cycle
        set[EV_IRQ] = devIrq & ~cur_ff.prevIrq;
        set[EV_ALL_TX_READY_N] = ~bus.allTxReadyN & ~cur_ff.prevTx;
        set[EV_ALL_RX_READY_N] = ~bus.allRxReadyN & ~cur_ff.prevRx;
        nxt_host.prevIrq = devIrq;
        nxt_host.prevTx = ~bus.allTxReadyN;
        nxt_host.prevRx = ~bus.allRxReadyN;
        nxt_host.evSt = (cur_ff.evSt & ~clr) | set;
        nxt_host.irq = |(nxt_host.evSt & nxt_host.evEn);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_ff <= '0;
            cur_ff.st <= H_IDLE;
            cur_ff.style <= CTRL_STYLE_RST;
            cur_ff.frcEn <= CTRL_FORCE_RST;
            cur_ff.csN <= 4'hf;
            cur_ff.rdN <= 1'b1;
            cur_ff.wrN <= 1'b1;
            cur_ff.dOeN <= 1'b1;
        end else begin
            cur_ff <= nxt_host;
        end
    end

    assign regRdata = cur_ff.rdata;
    assign irq = cur_ff.irq;
    assign bus.busStyle = cur_ff.style;
    assign bus.irqForceEnable = cur_ff.frcEn;
    assign bus.chanASelectN = cur_ff.csN[0];
    assign bus.chanBSelectN = cur_ff.csN[1];
    assign bus.chanCSelectN = cur_ff.csN[2];
    assign bus.chanDSelectN = cur_ff.csN[3];
    assign bus.addr = cur_ff.a;
    assign bus.rdStrobeN = cur_ff.rdN;
    assign bus.wrStrobeN = cur_ff.wrN;
    assign bus.hostData = cur_ff.dOut;
    assign bus.hostDataOeN = cur_ff.dOeN;
endmodule

// ==== qhs_checker.sv ====
// Pin-level assertions between the host and device ends
module qhs_checker
    import qhs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus style and selects
    input wire logic busStyle,
    input wire logic irqForceEnable,
    input wire logic chanASelectN,
    input wire logic chanBSelectN,
    input wire logic chanCSelectN,
    input wire logic chanDSelectN,
    // Strobes and data drive
    input wire logic rdStrobeN,
    input wire logic wrStrobeN,
    input wire logic hostDataOeN,
    input wire logic devDataOeN,
    // Interrupt pins
    input wire logic [3:0] chanIrqOut,
    input wire logic [3:0] chanIrqOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire logic [3:0] selN = {chanDSelectN, chanCSelectN, chanBSelectN, chanASelectN};

    unused_irq_low_a: assert property (!busStyle && !$past(busStyle) |->
        chanIrqOeN[3:1] == 3'h0 && chanIrqOut[3:1] == 3'h0) else $error("Unused interrupt pins not low");
    shared_irq_od_a: assert property (!busStyle && !$past(busStyle) && !chanIrqOeN[0] |->
        !chanIrqOut[0]) else $error("Shared interrupt driven high");
    force_line_low_a: assert property (!busStyle && !$past(busStyle) |->
        !irqForceEnable) else $error("Force input high in line mode");
    force_override_a: assert property (busStyle && irqForceEnable |=>
        chanIrqOeN == 4'h0) else $error("Forced interrupts not driven");
    strobe_read_a: assert property (busStyle && $onehot(~selN) && !rdStrobeN && wrStrobeN |=>
        !devDataOeN) else $error("Strobe read not answered");
    line_read_a: assert property (!busStyle && !chanASelectN && wrStrobeN |=>
        !devDataOeN) else $error("Line read not answered");
    no_select_a: assert property ((busStyle ? !$onehot(~selN) : chanASelectN) |=>
        devDataOeN) else $error("Data driven without select");
    bus_contention_a: assert property (!(!devDataOeN && !hostDataOeN))
        else $error("Both ends drive data");

    cover property (busStyle && !rdStrobeN && !devDataOeN);
    cover property (!busStyle && !chanASelectN && !wrStrobeN);
    cover property (busStyle && irqForceEnable);
endmodule

// ==== tb_top.sv ====
// Testbench joining host end and device end across the pin interface
module tb_top
    import qhs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] regAddr, chanIrq, modemIrqEnable, txReady, rxReady;
    logic [3:0] txDmaRequest, rxDmaRequest, extModeTxDma, extModeRxDma, coreSel;
    logic [31:0] regWdata, regRdata;
    logic regWr, regRd, irq, coreWr, coreRd, f;
    logic [7:0] coreRdata, coreWdata;
    logic [2:0] coreAddr;
    logic rdSeen = 1'b0;
    logic [31:0] rdQ[$];
    logic [14:0] wrQ[$];
    logic [6:0] rsQ[$];
    int bad_count = 0;
    int check_count = 0;
    int seed = 32'h0e5d;

    always #5 clk = ~clk;
    qhs_if bus();
    qhs_device_end i_qhs_device_end (.clk(clk), .reset_n(reset_n), .bus(bus), .chanIrq(chanIrq),
        .modemIrqEnable(modemIrqEnable), .txReady(txReady), .rxReady(rxReady), .txDmaRequest(txDmaRequest),
        .rxDmaRequest(rxDmaRequest), .extModeTxDma(extModeTxDma), .extModeRxDma(extModeRxDma),
        .coreRdata(coreRdata), .coreSel(coreSel), .coreAddr(coreAddr), .coreWdata(coreWdata),
        .coreWr(coreWr), .coreRd(coreRd));
    qhs_host_end i_qhs_host_end (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .bus(bus));
    qhs_checker i_qhs_checker (.clk(clk), .reset_n(reset_n), .busStyle(bus.busStyle),
        .irqForceEnable(bus.irqForceEnable), .chanASelectN(bus.chanASelectN), .chanBSelectN(bus.chanBSelectN),
        .chanCSelectN(bus.chanCSelectN), .chanDSelectN(bus.chanDSelectN), .rdStrobeN(bus.rdStrobeN),
        .wrStrobeN(bus.wrStrobeN), .hostDataOeN(bus.hostDataOeN), .devDataOeN(bus.devDataOeN),
        .chanIrqOut(bus.chanIrqOut), .chanIrqOeN(bus.chanIrqOeN));

    // Channel register file: byte tells which channel and address answered
    assign coreRdata = {coreSel, 1'b0, coreAddr} ^ 8'ha5;

    task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_pin(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Result watcher: read data and channel writes against the oldest note
    always @(posedge clk) begin
        if (rdSeen) check_reg("regRdata", rdQ.pop_front(), regRdata);
        if (coreWr === 1'b1) check_reg("core write", 32'(wrQ.pop_front()), {17'h0, coreSel, coreAddr, coreWdata});
        if (coreRd === 1'b1) check_pin("core read", 8'(rsQ.pop_front()), {1'b0, coreSel, coreAddr});
        rdSeen <= regRd;
    end

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic access(input logic [1:0] ch, input logic [2:0] a, input logic rd, input logic [7:0] d);
        int n;
        if (!rd) wrQ.push_back({4'b1 << ch, a, d});
        if (rd) rsQ.push_back({4'b1 << ch, a});
        reg_wr(OFS_ACCESS, {16'h0, d, 2'h0, rd, ch, a});
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (irq !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED access done expected 1 seen %b", irq);
            end_of_test();
        end
        if (rd) reg_rd(OFS_STATUS, {16'h0, {4'b1 << ch, 1'b0, a} ^ 8'ha5, 8'h00});
        reg_wr(OFS_IRQ_CLEAR, 32'h1);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        {regAddr, regWdata, regWr, regRd, chanIrq, modemIrqEnable, txReady, rxReady} = '0;
        {txDmaRequest, rxDmaRequest, extModeTxDma, extModeRxDma, f} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        reg_rd(OFS_CTRL, 32'h1);
        reg_rd(4'hf, 32'h0);
        reg_wr(OFS_IRQ_ENABLE, 32'h1);
        for (int s = 1; s >= 0; s--) begin
            reg_wr(OFS_CTRL, 32'(s));
            for (int c = 0; c < 4; c++) begin
                access(2'(c), 3'($random(seed)), 1'b0, 8'($random(seed)));
                access(2'(c), 3'($random(seed)), 1'b1, 8'h00);
            end
        end
        reg_wr(OFS_IRQ_ENABLE, 32'h0);
        rsQ.push_back(7'h08);
        reg_wr(OFS_ACCESS, 32'h20);
        repeat (10) @(posedge clk);
        check_pin("masked irq", 8'h0, 8'(irq));
        reg_wr(OFS_IRQ_ENABLE, 32'h1);
        #1 check_pin("enabled irq", 8'h1, 8'(irq));
        reg_wr(OFS_IRQ_CLEAR, 32'h1);
        #1 check_pin("cleared irq", 8'h0, 8'(irq));
        $display("test access done");
        for (int i = 0; i < 32; i++) begin
            f = 1'(i);
            reg_wr(OFS_CTRL, {30'h0, f, ~i[4]});
            chanIrq <= 4'($random(seed));
            modemIrqEnable <= 4'($random(seed));
            settle();
            if (i < 16) check_pin("irq pins", 8'(chanIrq & (modemIrqEnable | {4{f}})), 8'(bus.chanIrqLevel));
            else check_pin("line irq", {7'h0, ~|chanIrq}, 8'(bus.chanIrqLevel));
        end
        $display("test interrupt pins done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {txReady, rxReady, txDmaRequest, rxDmaRequest} <= 16'($random(seed));
            {extModeTxDma, extModeRxDma} <= 8'($random(seed));
            settle();
            check_pin("tx ready", {3'h0, ~|txReady, (extModeTxDma & txDmaRequest) | (~extModeTxDma & ~txReady)},
                {3'h0, bus.allTxReadyN, bus.chanTxReadyN});
            check_pin("rx ready", {3'h0, ~|rxReady, (extModeRxDma & rxDmaRequest) | (~extModeRxDma & ~rxReady)},
                {3'h0, bus.allRxReadyN, bus.chanRxReadyN});
        end
        $display("test ready pins done");
        check_pin("notes left", 8'h00, 8'(rsQ.size() + wrQ.size() + rdQ.size()));
        end_of_test();
    end
endmodule
